// >>> include/tlvi_pkg.sv
// package for the two-level vectored interrupt unit: register indices,
// field positions, reset values, flag-to-source map and handshake states.
// assumes APB with 32-bit data; byte address = register index * 4.
//
// Operation
// - fourteen sources, two levels, low after reset
// - several flags may request one source vector
// - flags set regardless of any enable bit
// - disabled pending flag raises no request
// - call vector once current instruction completes
// - return ends service, frees its priority level
// - global gate bit seven blocks every source
// - enable cleared mid-instruction may still be taken
// - vectoring clears external and timer0/1 flags only
// - flag still set after return re-requests
// - software setting a flag acts as event
// - high preempts low; nothing preempts high
// - higher level wins, then lowest order number
// - sample every cycle; best response five cycles
// - one instruction runs after return before call
// - worst unnested response is eighteen cycles
// - equal or lower level waits past return
// - vectors 0x0003 plus eight per order slot
// - enable and priority bits share positions
package tlvi_pkg;

  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int NSRC = 15;
  localparam int SRC_W = 4;
  localparam int NFLAG = 24;
  localparam int ADDR_W = 10;
  localparam int VEC_W = 16;

  // -----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_PRI_EN = 8'ha8;
  localparam logic [7:0] IDX_PRI_PRIO = 8'hb8;
  localparam logic [7:0] IDX_EXT_EN = 8'he6;
  localparam logic [7:0] IDX_EXT_PRIO = 8'hf6;
  localparam logic [7:0] IDX_PEND = 8'h10;
  localparam logic [7:0] IDX_STAT = 8'h11;

  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int GATE_BIT = 7;
  localparam int PRIO_RO_BIT = 7;
  localparam int EXT_RSVD_BIT = 6;
  localparam int PRI_SRC_N = 7;
  localparam int EXT_LOW_N = 6;
  localparam int RSVD_SRC = 13;
  localparam int PMATCH_SRC = 8;
  localparam int LAST_SRC = 14;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [NFLAG-1:0] PEND_RST = 24'h000000;
  localparam logic [7:0] PRIO_RO_VAL = 8'h80;
  // status word positions
  localparam int ST_REQ_BIT = 0;
  localparam int ST_LO_BIT = 1;
  localparam int ST_HI_BIT = 2;
  localparam int ST_HOLD_BIT = 3;
  localparam int ST_VEC_LSB = 16;

  // -----------------------------------------------------------------
  // vectors and timing
  // -----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam int BEST_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
  localparam int WORST_RESPONSE = 18;

  // -----------------------------------------------------------------
  // flag map: owning source of each flag, and flags cleared on vectoring
  // -----------------------------------------------------------------
  localparam logic [NFLAG-1:0][SRC_W-1:0] FLAG_SRC = {
    4'he, 4'he, 4'hc, 4'hc, 4'hb, 4'hb, 4'hb, 4'hb, 4'hb, 4'ha, 4'h9, 4'h7,
    4'h6, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h4, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [NFLAG-1:0] FLAG_HWCLR = 24'h00000f;

  typedef enum logic [1:0] {
    TLVI_IDLE = 2'b00,
    TLVI_REQ = 2'b01,
    TLVI_ACKED = 2'b11,
    TLVI_RETI = 2'b10
  } tlvi_state_e;

endpackage

// >>> include/tlvi_arb_if.sv
// carrier between the unit and one per-level first-request finder.
// assumes a purely combinational finder on the far side.
`timescale 1ns/10ps
`default_nettype none
interface tlvi_arb_if #(parameter int N = 15, parameter int IW = 4);
  logic [N-1:0] req;
  logic valid;
  logic [IW-1:0] idx;
  modport unit (output req, input valid, input idx);
  modport finder (input req, output valid, output idx);
endinterface
`default_nettype wire

// >>> core/tlvi_first_req.sv
// lowest-index request finder for one priority level.
// assumes combinational use; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module tlvi_first_req #(
  parameter int N = 15,
  parameter int IW = 4
) (
  // arbitration carrier
  tlvi_arb_if.finder arb
);
  always_comb begin
    arb.valid = 1'b0;
    arb.idx = '0;
    // scan from the top so the lowest order number is left standing
    for (int i = N - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.valid = 1'b1;
        arb.idx = IW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/tlvi_unit.sv
// two-level vectored interrupt unit with an APB register port.
// assumes the core acks a request only at an instruction boundary and
// reports return completion and every instruction completion.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module tlvi_unit
  import tlvi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral flag events, one-cycle pulses; port match is a held level with no flag
  input wire logic [NFLAG-1:0] flag_set,
  input wire logic port_match,
  // core handshake
  output logic irq_req,
  output logic [VEC_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic reti_done,
  input wire logic instr_done
);

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0] pri_en_q;
  logic [7:0] pri_prio_q;
  logic [7:0] ext_en_q;
  logic [7:0] ext_prio_q;
  logic [NFLAG-1:0] pend_q;
  logic [NFLAG-1:0] pend_d;
  logic act_hi_q;
  logic act_lo_q;
  tlvi_state_e state_q;
  tlvi_state_e state_d;
  logic irq_req_q;
  logic [VEC_W-1:0] irq_vector_q;
  logic [SRC_W-1:0] irq_src_q;
  logic irq_hi_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  logic [7:0] acc_idx;
  logic acc_ok;
  logic access;
  logic wr_fire;
  logic [31:0] rd_val;
  logic [31:0] stat_word;

  assign acc_idx = paddr[ADDR_W-1:2];
  assign access = psel && penable;
  // a write lands only on the edge where pready is seen high
  assign wr_fire = access && pready_q && pwrite && acc_ok;

  always_comb begin
    acc_ok = 1'b1;
    rd_val = '0;
    case (acc_idx)
      IDX_PRI_EN: rd_val = {24'h000000, pri_en_q};
      IDX_PRI_PRIO: rd_val = {24'h000000, pri_prio_q | PRIO_RO_VAL};
      IDX_EXT_EN: rd_val = {24'h000000, ext_en_q};
      IDX_EXT_PRIO: rd_val = {24'h000000, ext_prio_q};
      IDX_PEND: rd_val = {8'h00, pend_q};
      IDX_STAT: rd_val = stat_word;
      default: acc_ok = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      acc_ok = 1'b0;
    end
  end

  // one wait state: data is registered on the same edge that pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h00000000 : (acc_ok ? rd_val : 32'h00000000);
      pslverr_q <= !acc_ok;
    end else begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // enable and priority registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_en_q <= EN_RST;
      pri_prio_q <= PRIO_RST;
      ext_en_q <= EN_RST;
      ext_prio_q <= PRIO_RST;
    end else if (wr_fire) begin
      case (acc_idx)
        IDX_PRI_EN: pri_en_q <= pwdata[7:0];
        IDX_PRI_PRIO: pri_prio_q <= pwdata[7:0] & ~PRIO_RO_VAL;
        IDX_EXT_EN: ext_en_q <= pwdata[7:0];
        IDX_EXT_PRIO: ext_prio_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // per-source views of enable, level and pending
  // -----------------------------------------------------------------
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_hi;
  logic [NSRC-1:0] src_pend;
  logic [NSRC-1:0] src_live;

  always_comb begin
    src_en = '0;
    src_hi = '0;
    // first seven on primary bits, rest on extended bits 0..5 and 7
    src_en[PRI_SRC_N-1:0] = pri_en_q[PRI_SRC_N-1:0];
    src_hi[PRI_SRC_N-1:0] = pri_prio_q[PRI_SRC_N-1:0];
    src_en[PRI_SRC_N+EXT_LOW_N-1:PRI_SRC_N] = ext_en_q[EXT_LOW_N-1:0];
    src_hi[PRI_SRC_N+EXT_LOW_N-1:PRI_SRC_N] = ext_prio_q[EXT_LOW_N-1:0];
    src_en[LAST_SRC] = ext_en_q[7];
    src_hi[LAST_SRC] = ext_prio_q[7];
    // reserved slot never requests
    src_en[RSVD_SRC] = 1'b0;
  end

  always_comb begin
    src_pend = '0;
    // any flag of a source requests that source's single vector
    for (int f = 0; f < NFLAG; f++) begin
      if (pend_q[f]) begin
        src_pend[FLAG_SRC[f]] = 1'b1;
      end
    end
    // port match has no flag of its own; its level requests directly
    if (port_match) begin
      src_pend[PMATCH_SRC] = 1'b1;
    end
  end

  // global gate overrides every individual enable
  assign src_live = src_pend & src_en & {NSRC{pri_en_q[GATE_BIT]}};

  // -----------------------------------------------------------------
  // arbitration: one finder per level
  // -----------------------------------------------------------------
  tlvi_arb_if #(.N(NSRC), .IW(SRC_W)) arb_hi ();
  tlvi_arb_if #(.N(NSRC), .IW(SRC_W)) arb_lo ();

  assign arb_hi.req = src_live & src_hi;
  assign arb_lo.req = src_live & ~src_hi;

  tlvi_first_req #(.N(NSRC), .IW(SRC_W)) u_find_hi (
    .arb(arb_hi.finder)
  );
  tlvi_first_req #(.N(NSRC), .IW(SRC_W)) u_find_lo (
    .arb(arb_lo.finder)
  );

  logic win_valid;
  logic win_hi;
  logic [SRC_W-1:0] win_idx;
  logic win_allowed;

  always_comb begin
    // high level beats low regardless of order number
    win_hi = arb_hi.valid;
    win_valid = arb_hi.valid || arb_lo.valid;
    win_idx = arb_hi.valid ? arb_hi.idx : arb_lo.idx;
    // only a high request may interrupt a low routine; none a high one
    if (act_hi_q) begin
      win_allowed = 1'b0;
    end else if (act_lo_q) begin
      win_allowed = win_hi;
    end else begin
      win_allowed = win_valid;
    end
  end

  // -----------------------------------------------------------------
  // handshake with the core
  // -----------------------------------------------------------------
  logic ack_take;
  assign ack_take = irq_ack && irq_req_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TLVI_IDLE: begin
        if (win_allowed) begin
          state_d = TLVI_REQ;
        end
      end
      TLVI_REQ: begin
        if (ack_take) begin
          state_d = TLVI_ACKED;
        end else if (reti_done) begin
          state_d = TLVI_RETI;
        end else if (!win_allowed) begin
          // an enable cleared before the boundary withdraws the request
          state_d = TLVI_IDLE;
        end
      end
      TLVI_ACKED: begin
        // one settling cycle so cleared flags are not re-requested
        state_d = reti_done ? TLVI_RETI : TLVI_IDLE;
      end
      TLVI_RETI: begin
        // at least one more instruction completes before the next call
        if (instr_done) begin
          state_d = TLVI_IDLE;
        end
      end
      default: state_d = TLVI_IDLE;
    endcase
    if (reti_done && state_q != TLVI_RETI) begin
      state_d = TLVI_RETI;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TLVI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request and vector are re-decoded each clock outside ack, return, ACKED and RETI; the core takes them
  // only at an instruction boundary, so best case is detect plus the call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= VEC_RESET;
      irq_src_q <= '0;
      irq_hi_q <= 1'b0;
    end else if (ack_take || reti_done || state_q == TLVI_RETI
                 || state_q == TLVI_ACKED) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= win_allowed;
      if (win_allowed) begin
        irq_vector_q <= VEC_W'(VEC_BASE + VEC_W'(win_idx) * VEC_STEP);
        irq_src_q <= win_idx;
        irq_hi_q <= win_hi;
      end
    end
  end

  // -----------------------------------------------------------------
  // active level tracking
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else if (ack_take) begin
      if (irq_hi_q) begin
        act_hi_q <= 1'b1;
      end else begin
        act_lo_q <= 1'b1;
      end
    end else if (reti_done) begin
      // return closes the innermost routine, which is high if any
      if (act_hi_q) begin
        act_hi_q <= 1'b0;
      end else begin
        act_lo_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // pending flags
  // -----------------------------------------------------------------
  always_comb begin
    pend_d = pend_q;
    // software write replaces the flags; writing a one acts as an event
    if (wr_fire && acc_idx == IDX_PEND) begin
      pend_d = pwdata[NFLAG-1:0];
    end
    // vectoring clears only the external and timer 0/1 flags
    if (ack_take) begin
      for (int f = 0; f < NFLAG; f++) begin
        if (FLAG_HWCLR[f] && FLAG_SRC[f] == irq_src_q) begin
          pend_d[f] = 1'b0;
        end
      end
    end
    // events set flags whatever the enables; a set beats any clear
    pend_d = pend_d | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= PEND_RST;
    end else begin
      pend_q <= pend_d;
    end
  end

  // -----------------------------------------------------------------
  // status word and outputs
  // -----------------------------------------------------------------
  always_comb begin
    stat_word = '0;
    stat_word[ST_REQ_BIT] = irq_req_q;
    stat_word[ST_LO_BIT] = act_lo_q;
    stat_word[ST_HI_BIT] = act_hi_q;
    stat_word[ST_HOLD_BIT] = (state_q == TLVI_RETI);
    stat_word[ST_VEC_LSB +: VEC_W] = irq_vector_q;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_req_q;
  assign irq_vector = irq_vector_q;

endmodule
`default_nettype wire

// >>> bench/tlvi_unit_sva.sv
// checker for the interrupt unit, watching its top-level ports only.
// assumes an apb master that holds each request until pready.
`timescale 1ns/10ps
`default_nettype none
module tlvi_unit_sva
  import tlvi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and core
  input wire logic [NFLAG-1:0] flag_set,
  input wire logic port_match,
  input wire logic irq_req,
  input wire logic [VEC_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic reti_done,
  input wire logic instr_done
);
  logic gate_q;

  // shadow of the global gate, taken only on a completed write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == {IDX_PRI_EN, 2'b00}) begin
      gate_q <= pwdata[GATE_BIT];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RDY_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  AST_SERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("slave error without ready or with data");
  AST_GATE: assert property (!gate_q |=> !irq_req)
    else $error("request while global gate is off");
  AST_ACK_DROP: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request not dropped after acknowledge");
  AST_VEC_SLOT: assert property (irq_req |-> irq_vector[2:0] == 3'h3 &&
    irq_vector <= 16'h0073 && irq_vector != 16'h006b)
    else $error("vector outside the slot table");
  AST_RETI_QUIET: assert property (reti_done |=> !irq_req)
    else $error("request right after return");
  AST_RETI_GAP: assert property (reti_done ##1 !instr_done |=> !irq_req)
    else $error("request before the instruction after return");
  AST_REQ_HOLD: assert property (irq_req && !irq_ack && !reti_done && !psel &&
    !$past(psel) && !port_match && !$past(port_match) |=> irq_req)
    else $error("request withdrawn without cause");
endmodule
`default_nettype wire

// >>> bench/tlvi_core_model.sv
// behavioural core sequencer: instructions of bench-chosen length,
// calls taken only at instruction ends, returns on bench command.
`timescale 1ns/10ps
`default_nettype none
module tlvi_core_model
  import tlvi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // unit side
  input wire logic irq_req,
  input wire logic [VEC_W-1:0] irq_vector,
  output logic irq_ack,
  output logic reti_done,
  output logic instr_done,
  // bench side
  input wire logic [2:0] ilen,
  input wire logic reti_cmd,
  output logic [VEC_W-1:0] vec_q,
  output logic [7:0] acks_q
);
  logic [2:0] cnt_q;
  logic reti_q;

  // a call never splits an instruction
  assign instr_done = cnt_q == 3'h0 && !reti_q;
  assign reti_done = cnt_q == 3'h0 && reti_q;
  assign irq_ack = instr_done && irq_req;

  // call four cycles, return five, others one to eight (slow case is a divide)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      reti_q <= 1'b0;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      cnt_q <= irq_ack ? 3'h3 : (reti_cmd && !reti_q ? 3'h4 : ilen);
      reti_q <= reti_cmd && !reti_q && !irq_ack;
    end
  end

  // the vector is latched with the ack since the unit may move it later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= '0;
      acks_q <= '0;
    end else if (irq_ack) begin
      vec_q <= irq_vector;
      acks_q <= acks_q + 8'h1;
    end
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench: apb master, flag events and a behavioural core.
// assumes the checker is bound to the unit at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tlvi_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic port_match = 1'b0, reti_cmd = 1'b0, pready, pslverr, e, pm;
  logic irq_req, irq_ack, reti_done, instr_done;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic [NFLAG-1:0] flag_set = '0, fl;
  logic [VEC_W-1:0] irq_vector, vec_q;
  logic [7:0] acks_q;
  logic [2:0] ilen = 3'h0;
  logic [14:0] en, pr;
  int err_count = 0, comparisons = 0;

  always #20 pclk = ~pclk;
  always @(posedge pclk) ilen <= 3'($urandom);

  tlvi_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_set(flag_set), .port_match(port_match), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .reti_done(reti_done),
    .instr_done(instr_done));
  tlvi_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .reti_done(reti_done),
    .instr_done(instr_done), .ilen(ilen), .reti_cmd(reti_cmd), .vec_q(vec_q),
    .acks_q(acks_q));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stuck(input string what);
    chk(what, 32'h1, 32'h0);
    wrap_up();
  endtask

  // one apb transfer; read data and error land in d and e
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // the request stands until the rising edge that sees pready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stuck("apb answer");
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [NFLAG-1:0] f);
    @(posedge pclk);
    flag_set <= f;
    @(posedge pclk);
    flag_set <= '0;
  endtask

  task automatic wait_ack(input logic [VEC_W-1:0] exp);
    logic [7:0] a;
    int n;
    a = acks_q;
    n = 0;
    while (acks_q === a && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 80) stuck("core ack");
    chk("vector", {16'h0, exp}, {16'h0, vec_q});
  endtask

  // longer than the worst unnested response, so a missed block shows
  task automatic quiet();
    logic [7:0] a;
    a = acks_q;
    repeat (24) @(posedge pclk);
    chk("ack count", {24'h0, a}, {24'h0, acks_q});
  endtask

  task automatic do_reti();
    int n;
    reti_cmd <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (reti_done !== 1'b1 && n < 40);
    if (n >= 40) stuck("return");
    reti_cmd <= 1'b0;
  endtask

  function automatic logic [15:0] best(input logic [14:0] en, input logic [14:0] pr,
    input logic [23:0] fl, input logic pm);
    logic [14:0] p;
    p = '0;
    for (int f = 0; f < NFLAG; f++) if (fl[f]) p[FLAG_SRC[f]] = 1'b1;
    p[PMATCH_SRC] = pm;
    p = p & en;
    for (int l = 1; l >= 0; l--)
      for (int s = 0; s < NSRC; s++)
        if (p[s] && pr[s] == l[0]) return 16'(VEC_BASE + VEC_STEP * s);
    return 16'h0;
  endfunction

  initial begin
    void'($urandom(32'he6ff));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_PRI_EN, '0);
    chk("enable", 32'h0, d);
    apb(1'b0, IDX_PRI_PRIO, '0);
    chk("priority", 32'h80, d);
    apb(1'b0, IDX_EXT_PRIO, '0);
    chk("ext priority", 32'h0, d);
    apb(1'b0, 8'h00, '0);
    chk("slave error", 32'h1, {31'h0, e});
    $display("test reset ended");
    apb(1'b1, IDX_PRI_EN, 32'h01);
    pulse(24'h000001);
    quiet();
    apb(1'b0, IDX_PEND, '0);
    chk("flags", 32'h1, d);
    apb(1'b1, IDX_PRI_EN, 32'h81);
    wait_ack(16'h0003);
    apb(1'b0, IDX_PEND, '0);
    chk("flags", 32'h0, d);
    apb(1'b1, IDX_PRI_PRIO, 32'h0c);
    apb(1'b1, IDX_PRI_EN, 32'h8f);
    pulse(24'h000002);
    quiet();
    pulse(24'h000004);
    wait_ack(16'h0013);
    apb(1'b0, IDX_STAT, '0);
    chk("status", 32'h00130006, d);
    pulse(24'h000008);
    quiet();
    do_reti();
    wait_ack(16'h001b);
    do_reti();
    quiet();
    do_reti();
    wait_ack(16'h000b);
    do_reti();
    $display("test nesting ended");
    apb(1'b1, IDX_PRI_EN, 32'h90);
    apb(1'b1, IDX_PEND, 32'h10);
    wait_ack(16'h0023);
    apb(1'b0, IDX_PEND, '0);
    chk("flags", 32'h10, d);
    do_reti();
    wait_ack(16'h0023);
    apb(1'b1, IDX_PEND, '0);
    do_reti();
    $display("test software flag ended");
    for (int i = 0; i < 16; i++) begin
      en = 15'($urandom) | 15'h4000;
      pr = 15'($urandom);
      fl = 24'($urandom) | 24'h800000;
      pm = 1'($urandom);
      apb(1'b1, IDX_PRI_EN, {25'h0, en[6:0]});
      apb(1'b1, IDX_EXT_EN, {24'h0, en[14:7]});
      apb(1'b0, IDX_EXT_EN, '0);
      chk("ext enable", {24'h0, en[14:7]}, d);
      apb(1'b1, IDX_PRI_PRIO, {25'h0, pr[6:0]});
      apb(1'b1, IDX_EXT_PRIO, {24'h0, pr[14:7]});
      apb(1'b1, IDX_PEND, {8'h0, fl});
      port_match <= pm;
      apb(1'b1, IDX_PRI_EN, {24'h0, 1'b1, en[6:0]});
      wait_ack(best(en, pr, fl, pm));
      apb(1'b1, IDX_PRI_EN, '0);
      apb(1'b1, IDX_PEND, '0);
      port_match <= 1'b0;
      do_reti();
    end
    $display("test arbitration ended");
    wrap_up();
  end
endmodule

bind tlvi_unit tlvi_unit_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .flag_set(flag_set), .port_match(port_match),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .reti_done(reti_done),
  .instr_done(instr_done));
`default_nettype wire
